// File: lts_pkg.sv
// Package for the layered trigger sequencer: register map, fields, sources, timing.
// Assumes an APB slave with 32-bit data and a 10 MHz system clock.
package lts_pkg;
   // Register byte offsets
   localparam logic [7:0] REG_CTRL      = 8'h00;
   localparam logic [7:0] REG_SRC       = 8'h04;
   localparam logic [7:0] REG_ARM_CNT   = 8'h08;
   localparam logic [7:0] REG_SCAN_CNT  = 8'h0C;
   localparam logic [7:0] REG_MEAS_CNT  = 8'h10;
   localparam logic [7:0] REG_TIMER     = 8'h14;
   localparam logic [7:0] REG_SCAN_DLY  = 8'h18;
   localparam logic [7:0] REG_MEAS_DLY  = 8'h1C;
   localparam logic [7:0] REG_CAL_TIME  = 8'h20;
   localparam logic [7:0] REG_CAL_DATE  = 8'h24;
   localparam logic [7:0] REG_STATUS    = 8'h28;
   localparam logic [7:0] REG_CMD       = 8'h2C;
   // CTRL fields
   localparam int CTRL_CONT_BIT   = 0;
   localparam int CTRL_ABYP_BIT   = 1;
   localparam int CTRL_SBYP_BIT   = 2;
   localparam int CTRL_MBYP_BIT   = 3;
   localparam int CTRL_LIN_LSB    = 4;
   localparam int CTRL_LOUT_LSB   = 8;
   // SRC fields
   localparam int SRC_ARM_LSB     = 0;
   localparam int SRC_SCAN_LSB    = 4;
   localparam int SRC_MEAS_LSB    = 8;
   // CMD fields (write-one pulses)
   localparam int CMD_HALT_BIT    = 0;
   localparam int CMD_INIT_BIT    = 1;
   // Count fields
   localparam int CNT_INF_BIT     = 31;
   localparam logic [16:0] CNT_MAX = 17'h1869F;
   // Timer range in ms
   localparam logic [29:0] TMR_MAX_MS = 30'h3B9AC9FF;
   localparam logic [29:0] TMR_MIN_MS = 30'h0000_0001;
   // Time base
   localparam int CLK_HZ        = 10_000_000;
   localparam int MS_PER_S      = 1000;
   localparam int TICK_CYCLES   = CLK_HZ / MS_PER_S;
   // Reset values
   localparam logic [31:0] CTRL_RST = 32'h0000_0010;
   localparam logic [31:0] SRC_RST  = 32'h0000_0000;
   localparam logic [31:0] CNT_RST  = 32'h0000_0001;
   localparam logic [31:0] TMR_RST  = 32'h0000_0001;

   typedef enum logic [3:0] {
      LTS_SRC_IMM, LTS_SRC_EXT, LTS_SRC_MAN, LTS_SRC_BUS,
      LTS_SRC_LINK, LTS_SRC_TMR, LTS_SRC_CAL, LTS_SRC_HOLD
   } lts_src_t;

   typedef struct packed {
      logic ext;
      logic key;
      logic bus;
      logic link;
      logic tmr;
      logic cal;
   } lts_evt_t;
endpackage : lts_pkg

// File: lts_sequencer.sv
// Three-layer trigger sequencer (arm, scan, measure) with APB register access.
// Assumes event inputs arrive as pins (synchronised here) and a 10 MHz CLK.
`timescale 1ns/1ps
module lts_sequencer #(
   parameter int LINES       = 6,
   parameter int TICK        = lts_pkg::TICK_CYCLES
) (
   input  wire logic              CLK,
   input  wire logic              RST,
   input  wire logic              PSEL,
   input  wire logic              PENABLE,
   input  wire logic              PWRITE,
   input  wire logic [7:0]        PADDR,
   input  wire logic [31:0]       PWDATA,
   output logic      [31:0]       PRDATA,
   output logic                   PREADY,
   output logic                   PSLVERR,
   input  wire logic              EXT_MANUAL_TRIGGER_KEY_N,
   input  wire logic              MANUAL_TRIGGER_KEY,
   input  wire logic              BUS_TRIGGER,
   input  wire logic [LINES-1:0]  LINKED_TRIGGER_BUS_IN_N,
   output logic      [LINES-1:0]  LINKED_TRIGGER_BUS_OE_N,
   input  wire logic [31:0]       CAL_NOW_TIME,
   input  wire logic [31:0]       CAL_NOW_DATE,
   output logic                   DEVICE_ACTION,
   output logic                   IDLE
);
   // Line index is four bits wide; the tick needs at least one cycle
   if (LINES < 2 || LINES > 16 || TICK < 1)
   begin : g_bad_params
      $error("lts_sequencer: unsupported parameters");
   end

   typedef enum logic [2:0] {
      ST_IDLE, ST_ARM, ST_SCAN, ST_SDLY, ST_MEAS, ST_MDLY, ST_ACT
   } lts_state_t;

   // Registers
   logic [31:0] ctrl, src, arm_cnt, scan_cnt, meas_cnt, tmr, sdly, mdly, ctime, cdate;
   lts_state_t  state;

   // APB decode
   wire         wr     = PSEL && PENABLE && PWRITE;
   wire         rd_sel = PSEL && !PWRITE;
   wire         hit    = (PADDR[1:0] == 2'h0) && (PADDR <= lts_pkg::REG_CMD);
   wire         w_cmd  = wr && PADDR == lts_pkg::REG_CMD;
   wire [3:0]   lin    = ctrl[lts_pkg::CTRL_LIN_LSB +: 4];
   wire [3:0]   lout   = ctrl[lts_pkg::CTRL_LOUT_LSB +: 4];
   wire         line_bad = (PWDATA[lts_pkg::CTRL_LIN_LSB +: 4] ==
                            PWDATA[lts_pkg::CTRL_LOUT_LSB +: 4]) ||
                           (PWDATA[lts_pkg::CTRL_LIN_LSB +: 4] >= 4'(LINES)) ||
                           (PWDATA[lts_pkg::CTRL_LOUT_LSB +: 4] >= 4'(LINES));
   wire         hi_set  = PWDATA[31:30] != 2'h0;
   wire         tmr_bad = hi_set || PWDATA[29:0] < lts_pkg::TMR_MIN_MS ||
                          PWDATA[29:0] > lts_pkg::TMR_MAX_MS;
   wire         dly_bad = hi_set || PWDATA[29:0] > lts_pkg::TMR_MAX_MS;
   wire         cnt_bad = !PWDATA[lts_pkg::CNT_INF_BIT] &&
                          (PWDATA[16:0] > lts_pkg::CNT_MAX || PWDATA[16:0] == 17'h0);
   wire         is_cnt  = PADDR == lts_pkg::REG_ARM_CNT || PADDR == lts_pkg::REG_SCAN_CNT ||
                          PADDR == lts_pkg::REG_MEAS_CNT;
   wire         is_dly  = PADDR == lts_pkg::REG_SCAN_DLY || PADDR == lts_pkg::REG_MEAS_DLY;
   wire         bad     = !hit || (PWRITE &&
                          ((PADDR == lts_pkg::REG_CTRL && line_bad)
                          || (PADDR == lts_pkg::REG_TIMER && tmr_bad)
                          || (is_dly && dly_bad)
                          || (is_cnt && cnt_bad)));
   wire         wok     = wr && !bad;
   wire         halt    = w_cmd && !bad && PWDATA[lts_pkg::CMD_HALT_BIT];
   wire         init    = w_cmd && !bad && PWDATA[lts_pkg::CMD_INIT_BIT];
   assign PREADY  = 1'b1;
   assign PSLVERR = PSEL && PENABLE && bad;

   // Pin synchronisers: three stages, change once stages two and three agree
   localparam int NSYNC = 3 + LINES;
   wire [NSYNC-1:0] raw = {~LINKED_TRIGGER_BUS_IN_N, BUS_TRIGGER, MANUAL_TRIGGER_KEY,
                           ~EXT_MANUAL_TRIGGER_KEY_N};
   logic [NSYNC-1:0] s1, s2, s3, lvl, rise;
   genvar g;
   generate
      for (g = 0; g < NSYNC; g++)
      begin : g_sync
         always_ff @(posedge CLK)
         begin
            s1[g] <= RST ? 1'b0 : raw[g];
            s2[g] <= RST ? 1'b0 : s1[g];
            s3[g] <= RST ? 1'b0 : s2[g];
            lvl[g] <= RST ? 1'b0 : ((s2[g] == s3[g]) ? s3[g] : lvl[g]);
         end
         assign rise[g] = (s2[g] == s3[g]) && s3[g] && !lvl[g];
      end
   endgenerate

   // Millisecond tick
   logic [$clog2(TICK+1)-1:0] pre;
   wire ms = pre == ($bits(pre))'(TICK - 1);
   always_ff @(posedge CLK)
      pre <= (RST || ms) ? '0 : pre + 1'b1;

   // Scan timer: interval expiry latched until the next scan starts
   logic [29:0] tcnt;
   logic        tmr_due;
   wire         scan_start;
   wire         tmr_exp = ms && (tcnt == tmr[29:0] - 30'h1);
   always_ff @(posedge CLK)
   begin
      if (RST || state == ST_IDLE)
         tcnt <= '0;
      else if (ms)
         tcnt <= tmr_exp ? '0 : tcnt + 30'h1;
   end
   always_ff @(posedge CLK)
      tmr_due <= (RST || state == ST_IDLE) ? 1'b0 :
                 tmr_exp ? 1'b1 : (scan_start ? 1'b0 : tmr_due);

   lts_pkg::lts_evt_t ev;
   assign ev.ext  = rise[0];
   assign ev.key  = rise[1];
   assign ev.bus  = rise[2];
   assign ev.link = rise[3 + lin];
   assign ev.tmr  = tmr_due;
   assign ev.cal  = CAL_NOW_TIME == ctime && CAL_NOW_DATE == cdate;

   // Per-layer event selection
   function automatic logic layer_evt(input logic [3:0] s, input lts_pkg::lts_evt_t e,
                                      input logic tmr_ok, input logic cal_ok);
      case (lts_pkg::lts_src_t'(s))
         lts_pkg::LTS_SRC_IMM:  layer_evt = 1'b1;
         lts_pkg::LTS_SRC_EXT:  layer_evt = e.ext || e.key;
         lts_pkg::LTS_SRC_MAN:  layer_evt = e.key;
         lts_pkg::LTS_SRC_BUS:  layer_evt = e.bus || e.key;
         lts_pkg::LTS_SRC_LINK: layer_evt = e.link || e.key;
         lts_pkg::LTS_SRC_TMR:  layer_evt = tmr_ok && (e.tmr || e.key);
         lts_pkg::LTS_SRC_CAL:  layer_evt = cal_ok && e.cal;
         lts_pkg::LTS_SRC_HOLD: layer_evt = 1'b0;
         default:               layer_evt = 1'b0;
      endcase
   endfunction

   logic        arm_first, scan_first, meas_first;
   logic [16:0] arm_done, scan_done, meas_done;
   logic [29:0] dcnt;
   wire a_evt = arm_first && ctrl[lts_pkg::CTRL_ABYP_BIT] ||
                layer_evt(src[lts_pkg::SRC_ARM_LSB +: 4], ev, 1'b1, 1'b1);
   wire s_evt = scan_first && ctrl[lts_pkg::CTRL_SBYP_BIT] ||
                scan_first && src[lts_pkg::SRC_SCAN_LSB +: 4] == 4'(lts_pkg::LTS_SRC_TMR) ||
                layer_evt(src[lts_pkg::SRC_SCAN_LSB +: 4], ev, 1'b1, 1'b0);
   wire m_evt = meas_first && ctrl[lts_pkg::CTRL_MBYP_BIT] ||
                layer_evt(src[lts_pkg::SRC_MEAS_LSB +: 4], ev, 1'b1, 1'b0);
   assign scan_start = state == ST_SCAN && s_evt;
   wire dly_done = ms && dcnt == 30'h0;
   wire meas_last = !meas_cnt[lts_pkg::CNT_INF_BIT] && meas_done + 17'h1 >= meas_cnt[16:0];
   wire scan_last = !scan_cnt[lts_pkg::CNT_INF_BIT] && scan_done + 17'h1 >= scan_cnt[16:0];
   wire arm_last  = !arm_cnt[lts_pkg::CNT_INF_BIT] && arm_done + 17'h1 >= arm_cnt[16:0];
   wire cont      = ctrl[lts_pkg::CTRL_CONT_BIT];

   lts_state_t next_state;
   always_comb
   begin
      next_state = state;
      case (state)
         ST_IDLE: if (ev.key || cont || init) next_state = ST_ARM;
         ST_ARM:  if (a_evt) next_state = ST_SCAN;
         ST_SCAN: if (s_evt) next_state = (sdly[29:0] == 30'h0) ? ST_MEAS : ST_SDLY;
         ST_SDLY: if (dly_done) next_state = ST_MEAS;
         ST_MEAS: if (m_evt) next_state = (mdly[29:0] == 30'h0) ? ST_ACT : ST_MDLY;
         ST_MDLY: if (dly_done) next_state = ST_ACT;
         ST_ACT:
            if (!meas_last) next_state = ST_MEAS;
            else if (!scan_last) next_state = ST_SCAN;
            else if (!arm_last) next_state = ST_ARM;
            else next_state = cont ? ST_ARM : ST_IDLE;
         default: next_state = ST_IDLE;
      endcase
      if (halt)
         next_state = ST_IDLE;
   end

   wire leaving_idle = state == ST_IDLE && next_state == ST_ARM;
   wire act_meas = state == ST_ACT && !meas_last;
   wire act_scan = state == ST_ACT && meas_last && !scan_last;
   wire act_arm  = state == ST_ACT && meas_last && scan_last && !arm_last;
   wire act_top  = state == ST_ACT && meas_last && scan_last && arm_last;

   always_ff @(posedge CLK)
   begin
      if (RST)
         state <= ST_IDLE;
      else
         state <= next_state;
   end

   // Layer pass counters and first-pass flags
   always_ff @(posedge CLK)
   begin
      if (RST || leaving_idle || act_top)
      begin
         arm_done   <= '0;
         arm_first  <= 1'b1;
      end
      else if (act_arm)
      begin
         arm_done   <= arm_done + 17'h1;
         arm_first  <= 1'b0;
      end
   end
   always_ff @(posedge CLK)
   begin
      if (RST || leaving_idle || act_top || act_arm)
      begin
         scan_done  <= '0;
         scan_first <= 1'b1;
      end
      else if (act_scan)
      begin
         scan_done  <= scan_done + 17'h1;
         scan_first <= 1'b0;
      end
   end
   always_ff @(posedge CLK)
   begin
      if (RST || state != ST_ACT && state != ST_MEAS && state != ST_MDLY)
      begin
         meas_done  <= '0;
         meas_first <= 1'b1;
      end
      else if (act_meas)
      begin
         meas_done  <= meas_done + 17'h1;
         meas_first <= 1'b0;
      end
   end

   // Delay counter in ms, loaded on entry to a delay state
   always_ff @(posedge CLK)
   begin
      if (RST)
         dcnt <= '0;
      else if (state == ST_SCAN)
         dcnt <= sdly[29:0] - 30'h1;
      else if (state == ST_MEAS)
         dcnt <= mdly[29:0] - 30'h1;
      else if (ms && dcnt != 30'h0)
         dcnt <= dcnt - 30'h1;
   end

   // Register writes
   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         ctrl <= lts_pkg::CTRL_RST;
         src  <= lts_pkg::SRC_RST;
         arm_cnt <= lts_pkg::CNT_RST;
         scan_cnt <= lts_pkg::CNT_RST;
         meas_cnt <= lts_pkg::CNT_RST;
         tmr  <= lts_pkg::TMR_RST;
         sdly <= '0;
         mdly <= '0;
         ctime <= '0;
         cdate <= '0;
      end
      else if (wok)
      begin
         case (PADDR)
            lts_pkg::REG_CTRL:     ctrl <= {20'h0, PWDATA[11:0]};
            lts_pkg::REG_SRC:      src  <= {20'h0, PWDATA[11:0]};
            lts_pkg::REG_ARM_CNT:  arm_cnt  <= {PWDATA[31], 14'h0, PWDATA[16:0]};
            lts_pkg::REG_SCAN_CNT: scan_cnt <= {PWDATA[31], 14'h0, PWDATA[16:0]};
            lts_pkg::REG_MEAS_CNT: meas_cnt <= {PWDATA[31], 14'h0, PWDATA[16:0]};
            lts_pkg::REG_TIMER:    tmr  <= {2'h0, PWDATA[29:0]};
            lts_pkg::REG_SCAN_DLY: sdly <= {2'h0, PWDATA[29:0]};
            lts_pkg::REG_MEAS_DLY: mdly <= {2'h0, PWDATA[29:0]};
            lts_pkg::REG_CAL_TIME: ctime <= PWDATA;
            lts_pkg::REG_CAL_DATE: cdate <= PWDATA;
            default: ;
         endcase
      end
   end

   // Read mux
   wire [31:0] status = {9'h0, state == ST_ACT, 3'h0, state == ST_IDLE, 1'b0, 17'(state)};
   wire [31:0] rmux =
      PADDR == lts_pkg::REG_CTRL     ? ctrl     :
      PADDR == lts_pkg::REG_SRC      ? src      :
      PADDR == lts_pkg::REG_ARM_CNT  ? arm_cnt  :
      PADDR == lts_pkg::REG_SCAN_CNT ? scan_cnt :
      PADDR == lts_pkg::REG_MEAS_CNT ? meas_cnt :
      PADDR == lts_pkg::REG_TIMER    ? tmr      :
      PADDR == lts_pkg::REG_SCAN_DLY ? sdly     :
      PADDR == lts_pkg::REG_MEAS_DLY ? mdly     :
      PADDR == lts_pkg::REG_CAL_TIME ? ctime    :
      PADDR == lts_pkg::REG_CAL_DATE ? cdate    :
      PADDR == lts_pkg::REG_STATUS   ? status   : 32'h0;
   always_ff @(posedge CLK)
      PRDATA <= RST ? 32'h0 : ((rd_sel && !PENABLE && hit) ? rmux : PRDATA);

   // Outputs: action pulse and output trigger line driven low (open drain) on action
   always_ff @(posedge CLK)
   begin
      DEVICE_ACTION <= RST ? 1'b0 : state == ST_ACT;
      IDLE          <= RST ? 1'b1 : next_state == ST_IDLE;
   end
   generate
      for (g = 0; g < LINES; g++)
      begin : g_lout
         always_ff @(posedge CLK)
            LINKED_TRIGGER_BUS_OE_N[g] <= RST ? 1'b1 : !(state == ST_ACT && lout == 4'(g));
      end
   endgenerate
endmodule : lts_sequencer

// File: lts_properties.sv
// Port checker for the layered trigger sequencer.
// Assumes one clock domain with a synchronous active-high reset.
`timescale 1ns/1ps
module lts_properties #(
   parameter int LINES = 6
) (
   input wire logic             CLK,
   input wire logic             RST,
   input wire logic             PSEL,
   input wire logic             PENABLE,
   input wire logic             PWRITE,
   input wire logic [7:0]       PADDR,
   input wire logic [31:0]      PWDATA,
   input wire logic             PREADY,
   input wire logic             PSLVERR,
   input wire logic [LINES-1:0] LINKED_TRIGGER_BUS_OE_N,
   input wire logic             DEVICE_ACTION,
   input wire logic             IDLE
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RST);
   wire logic acc = PSEL && PENABLE;
   wire logic wr  = acc && PWRITE;
   wire logic big = !PWDATA[31] && (PWDATA[16:0] > lts_pkg::CNT_MAX);
   wire logic tbad = (PWDATA == 32'h0) || (PWDATA > {2'h0, lts_pkg::TMR_MAX_MS});
   wire logic halt_wr = wr && PADDR == lts_pkg::REG_CMD && PWDATA[0];
   a_zero_wait: assert property (acc |-> PREADY)
      else $error("access phase without ready");
   a_bad_addr: assert property (acc && (PADDR > 8'h2C || PADDR[1:0] != 2'h0) |-> PSLVERR)
      else $error("unmapped access not refused");
   a_timer_range: assert property (wr && PADDR == lts_pkg::REG_TIMER && tbad |-> PSLVERR)
      else $error("timer value out of range accepted");
   a_scan_cnt: assert property (wr && PADDR == lts_pkg::REG_SCAN_CNT && big |-> PSLVERR)
      else $error("scan count above limit accepted");
   a_arm_cnt: assert property (wr && PADDR == lts_pkg::REG_ARM_CNT && big |-> PSLVERR)
      else $error("arm count above limit accepted");
   a_halt_idle: assert property (halt_wr |-> ##[1:4] IDLE)
      else $error("halt did not reach idle");
   a_idle_quiet: assert property (IDLE && $past(IDLE) |-> !DEVICE_ACTION)
      else $error("device action while idle");
   a_one_line: assert property ($countones(~LINKED_TRIGGER_BUS_OE_N) <= 1)
      else $error("more than one trigger line driven");
   a_idle_lines: assert property (IDLE && $past(IDLE) |-> &LINKED_TRIGGER_BUS_OE_N)
      else $error("trigger line driven while idle");
   c_action: cover property (DEVICE_ACTION);
   c_leave_idle: cover property ($fell(IDLE));
   c_refused: cover property (acc && PSLVERR);
endmodule : lts_properties

// File: lts_far_end.sv
// Far-side model: external trigger, key, bus controller, linked lines, calendar.
// Assumes pulse is called right after a rising clock edge.
`timescale 1ns/1ps
module lts_far_end #(
   parameter int          LINES      = 6,
   parameter int          IN_LINE    = 1,
   parameter logic [31:0] MATCH_TIME = 32'h0000_1234,
   parameter logic [31:0] MATCH_DATE = 32'h0000_5678
) (
   input  wire logic        clk,
   output logic             ext_manual_trigger_key_n,
   output logic             key,
   output logic             bus_manual_trigger_key,
   output logic [LINES-1:0] line_drv_n,
   output logic [31:0]      now_time,
   output logic [31:0]      now_date
);
   initial
   begin
      ext_manual_trigger_key_n = 1'b1;
      key = 1'b0;
      bus_manual_trigger_key = 1'b0;
      line_drv_n = '1;
      now_time = 32'h0;
      now_date = 32'h0;
   end
   // Kinds: 0 external, 1 key, 2 bus, 3 linked line, 4 calendar match
   task automatic pulse(input int kind);
      case (kind)
         0: ext_manual_trigger_key_n <= 1'b0;
         1: key <= 1'b1;
         2: bus_manual_trigger_key <= 1'b1;
         3: line_drv_n[IN_LINE] <= 1'b0; // Input line only
         default: {now_time, now_date} <= {MATCH_TIME, MATCH_DATE};
      endcase
      // Four clocks: enough for the pin filter, short enough not to hide the action
      repeat (4) @(posedge clk);
      ext_manual_trigger_key_n <= 1'b1;
      key <= 1'b0;
      bus_manual_trigger_key <= 1'b0;
      line_drv_n <= '1;
      now_time <= MATCH_TIME + 32'h1;
   endtask : pulse
endmodule : lts_far_end

// File: layered_trigger_sequencer_tb.sv
// Self-checking bench for the layered trigger sequencer.
// Assumes lts_far_end drives the event pins; a millisecond is shortened to 4 cycles.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_mismatch++; \
   $display("[FAIL] %s expected %0h seen %0h", nm, e, g); end end
module layered_trigger_sequencer_tb;
   localparam int LINES = 6;
   logic             clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]       paddr = 8'h00;
   logic [31:0]      pwdata = 32'h0, prdata, now_time, now_date;
   logic             pready, pslverr, ext_n, key, bus_manual_trigger_key, action, idle;
   logic [LINES-1:0] drv_n, oe_n;
   wire logic [LINES-1:0] line_n = drv_n & oe_n;
   int               n_mismatch = 0, tests_run = 0;
   always #50 clk = ~clk;
   lts_sequencer #(.LINES(LINES), .TICK(4)) i_dut (
      .CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(pslverr), .EXT_MANUAL_TRIGGER_KEY_N(ext_n), .MANUAL_TRIGGER_KEY(key),
      .BUS_TRIGGER(bus_manual_trigger_key), .LINKED_TRIGGER_BUS_IN_N(line_n),
      .LINKED_TRIGGER_BUS_OE_N(oe_n), .CAL_NOW_TIME(now_time),
      .CAL_NOW_DATE(now_date), .DEVICE_ACTION(action), .IDLE(idle));
   lts_far_end #(.LINES(LINES)) i_far (
      .clk(clk), .ext_manual_trigger_key_n(ext_n), .key(key), .bus_manual_trigger_key(bus_manual_trigger_key),
      .line_drv_n(drv_n), .now_time(now_time), .now_date(now_date));
   task automatic report_and_stop;
      $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : report_and_stop
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
      int n;
      n = 0;
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      q = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
      if (pready !== 1'b1)
      begin
         n_mismatch++;
         report_and_stop();
      end
   endtask : apb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic        e;
      apb(1'b1, a, d, q, e);
   endtask : wr
   // Cycles until the next action; equals bound when none came
   task automatic wait_act(input int bound, output int n);
      n = 0;
      while (n < bound)
      begin
         @(negedge clk);
         if (action === 1'b1)
         begin
            `CHK("output line with action", 1'b0, oe_n[0])
            break;
         end
         n++;
      end
      @(posedge clk);
   endtask : wait_act
   task automatic wait_idle;
      int n;
      n = 0;
      do
      begin
         @(negedge clk);
         n++;
      end
      while (idle !== 1'b1 && n < 300);
      `CHK("idle reached", 1'b1, idle)
      if (idle !== 1'b1)
         report_and_stop();
      @(posedge clk);
   endtask : wait_idle
   task automatic start(input logic [31:0] src, input logic [31:0] ctrl);
      wr(lts_pkg::REG_SRC, src);
      wr(lts_pkg::REG_CTRL, ctrl);
      wr(lts_pkg::REG_CMD, 32'h2);
   endtask : start
   task automatic t_regs;
      logic [31:0] q;
      logic        e;
      apb(1'b0, lts_pkg::REG_CTRL, 32'h0, q, e);
      `CHK("ctrl reset", lts_pkg::CTRL_RST, q)
      apb(1'b0, lts_pkg::REG_ARM_CNT, 32'h0, q, e);
      `CHK("arm count reset", lts_pkg::CNT_RST, q)
      apb(1'b0, 8'h30, 32'h0, q, e);
      `CHK("unmapped refused", 1'b1, e)
      apb(1'b1, lts_pkg::REG_TIMER, 32'h0, q, e);
      `CHK("timer zero refused", 1'b1, e)
      apb(1'b1, lts_pkg::REG_TIMER, 32'h3B9A_C9FF, q, e);
      `CHK("timer max taken", 1'b0, e)
      apb(1'b1, lts_pkg::REG_SCAN_CNT, 32'h0001_86A0, q, e);
      `CHK("scan count over refused", 1'b1, e)
      apb(1'b1, lts_pkg::REG_SCAN_CNT, 32'h0001_869F, q, e);
      `CHK("scan count max taken", 1'b0, e)
      wr(lts_pkg::REG_SCAN_CNT, 32'h1);
      wr(lts_pkg::REG_CAL_TIME, 32'h0000_1234);
      wr(lts_pkg::REG_CAL_DATE, 32'h0000_5678);
   endtask : t_regs
   task automatic t_sources;
      int         n;
      logic [3:0] src [8] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h1, 4'h3, 4'h4, 4'h6};
      int         kind [8] = '{0, 1, 2, 3, 1, 1, 1, 4};
      for (int l = 0; l < 2; l++)
         for (int i = 0; i < 8 - l; i++)
         begin
            start(32'(src[i]) << (4 * l), lts_pkg::CTRL_RST);
            wait_act(30, n);
            `CHK("no action before event", 30, n)
            i_far.pulse(kind[i]);
            wait_act(40, n);
            `CHK("action after event", 1'b1, n < 40)
            wait_idle();
         end
   endtask : t_sources
   task automatic t_hold;
      int n;
      for (int l = 0; l < 2; l++)
      begin
         start(32'h7 << (4 * l), lts_pkg::CTRL_RST);
         for (int k = 0; k < 4; k++)
            i_far.pulse(k);
         wait_act(20, n);
         `CHK("held source quiet", 20, n)
         wr(lts_pkg::REG_SRC, 32'h0);
         wait_act(40, n);
         `CHK("immediate source runs", 1'b1, n < 40)
         wait_idle();
      end
   endtask : t_hold
   task automatic t_bypass_timer;
      int n;
      wr(lts_pkg::REG_SCAN_CNT, 32'h2);
      start(32'h20, lts_pkg::CTRL_RST | 32'h4);
      wait_act(40, n);
      `CHK("first pass bypassed", 1'b1, n < 40)
      wait_act(30, n);
      `CHK("second pass waits", 30, n)
      i_far.pulse(1);
      wait_act(40, n);
      `CHK("key starts scan", 1'b1, n < 40)
      wait_idle();
      wr(lts_pkg::REG_TIMER, 32'hA);
      wr(lts_pkg::REG_SCAN_CNT, 32'h3);
      start(32'h50, lts_pkg::CTRL_RST);
      wait_act(15, n);
      `CHK("first timed scan at once", 1'b1, n < 15)
      wait_act(60, n);
      `CHK("next scan on interval", 1'b1, n >= 30 && n < 50)
      i_far.pulse(1);
      wait_act(20, n);
      `CHK("key starts timed scan", 1'b1, n < 20)
      wait_idle();
      wr(lts_pkg::REG_SCAN_CNT, 32'h1);
   endtask : t_bypass_timer
   task automatic t_meas_bypass;
      int n;
      wr(lts_pkg::REG_MEAS_CNT, 32'h2);
      start(32'h200, lts_pkg::CTRL_RST | 32'h8);
      wait_act(40, n);
      `CHK("measure bypass first pass", 1'b1, n < 40)
      wait_act(30, n);
      `CHK("measure second pass waits", 30, n)
      i_far.pulse(1);
      wait_act(40, n);
      `CHK("key takes measure", 1'b1, n < 40)
      wait_idle();
      wr(lts_pkg::REG_MEAS_CNT, 32'h1);
   endtask : t_meas_bypass
   task automatic t_delay;
      int         n;
      logic [7:0] reg_of [2] = '{lts_pkg::REG_SCAN_DLY, lts_pkg::REG_MEAS_DLY};
      for (int i = 0; i < 2; i++)
      begin
         wr(reg_of[i], 32'h5);
         start(32'h0, lts_pkg::CTRL_RST);
         wait_act(80, n);
         `CHK("delay honoured", 1'b1, n >= 18 && n < 60)
         wait_idle();
         wr(reg_of[i], 32'h0);
      end
   endtask : t_delay
   task automatic t_halt;
      int n;
      wr(lts_pkg::REG_ARM_CNT, 32'h8000_0000);
      start(32'h0, lts_pkg::CTRL_RST | 32'h1);
      for (int i = 0; i < 2; i++)
      begin
         wait_act(40, n);
         `CHK("continuous restart", 1'b1, n < 40)
      end
      wr(lts_pkg::REG_CTRL, lts_pkg::CTRL_RST);
      wr(lts_pkg::REG_CMD, 32'h1);
      wait_idle();
      wait_act(30, n);
      `CHK("halted quiet", 30, n)
      i_far.pulse(1);
      wait_act(40, n);
      `CHK("key leaves idle", 1'b1, n < 40)
      wr(lts_pkg::REG_CMD, 32'h1);
      wait_idle();
      wr(lts_pkg::REG_ARM_CNT, 32'h1);
   endtask : t_halt
   initial
   begin
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_regs();
      t_sources();
      t_hold();
      t_bypass_timer();
      t_meas_bypass();
      t_delay();
      t_halt();
      report_and_stop();
   end
endmodule : layered_trigger_sequencer_tb
bind lts_sequencer lts_properties #(.LINES(LINES)) i_props (
   .CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
   .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
   .LINKED_TRIGGER_BUS_OE_N(LINKED_TRIGGER_BUS_OE_N),
   .DEVICE_ACTION(DEVICE_ACTION), .IDLE(IDLE));
